// ### core/fci_cycle_timer.v
// Down counter that times one phase of a bus cycle
// Assumes load and count come from the caller's state machine
`include "fci_defs.vh"
module fci_cycle_timer (
    input wire mclk,
    input wire rst_n,
    input wire load,
    input wire [`FCI_CW-1:0] value,
    output wire done
);
    reg [`FCI_CW-1:0] cnt;
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= {`FCI_CW{1'b0}};
        end else if (load) begin
            cnt <= value;
        end else if (cnt != {`FCI_CW{1'b0}}) begin
            cnt <= cnt - 1'b1;
        end
    end
    assign done = (cnt == {`FCI_CW{1'b0}});
endmodule // fci_cycle_timer

// ### core/fci_host_ctrl.v
// Host controller driving a byte-wide flash through its strobe pins
// Assumes pins sampled synchronously to mclk; data pin split in/out/oe
// Operation
// R1 - Write enable low marks a write cycle
// R2 - Chip enable low selects; high idles device
// R3 - Reset pin low powers down, clears state
// R4 - Host keeps reset pin high otherwise
// R5 - Output enable low only for reads
// R6 - Twenty-one bit byte address selects byte
// R7 - Device drives reads, host drives writes
// R8 - Ready flag low while engine busy
// R9 - Ready high in powerdown, ID, suspend
// R10 - Read: CE low, OE low, WE high
// R11 - Two-cycle erase and program sequences
// R12 - FFH returns device to array read
// R13 - Suspend command pauses an erase
// R14 - Erase targets one of 32 blocks
// R15 - Setup command precedes confirm or data
// R16 - Read-array command before array reads
// R17 - Device enters status read after operation
// R18 - ID codes at addresses zero and one
// R19 - Data latched on write-enable rising edge
`include "fci_defs.vh"
module fci_host_ctrl (
    input wire mclk,
    input wire rst_n,
    input wire req_valid,
    input wire [2:0] req_op,
    input wire [`FCI_AW-1:0] req_addr,
    input wire [`FCI_DW-1:0] req_data,
    output reg req_ready,
    output reg rsp_valid,
    output reg [`FCI_DW-1:0] rsp_data,
    output reg engine_busy,
    output reg reset_powerdown_n,
    output reg chip_enable_n,
    output reg output_enable_n,
    output reg write_enable_n,
    output reg [`FCI_AW-1:0] byte_address_bus,
    output reg [`FCI_DW-1:0] byte_data_out,
    output reg byte_data_oe_n,
    input wire [`FCI_DW-1:0] byte_data_in,
    input wire engine_ready_flag
);
    localparam S_IDLE = 3'h0;
    localparam S_SETUP = 3'h1;
    localparam S_STROBE = 3'h2;
    localparam S_HOLD = 3'h3;
    localparam S_GAP = 3'h4;
    localparam S_PDN = 3'h5;
    localparam S_WAKE = 3'h6;

    reg [2:0] state;
    reg [2:0] op;
    reg second;
    reg is_read;
    reg [`FCI_DW-1:0] wr_byte;
    reg [`FCI_DW-1:0] data_byte;
    reg tload;
    reg [`FCI_CW-1:0] tval;
    wire tdone;

    // One shared timer paces every phase of every bus cycle
    fci_cycle_timer u_timer (
        .mclk(mclk),
        .rst_n(rst_n),
        .load(tload),
        .value(tval),
        .done(tdone)
    );

    // First byte of each operation: setup command or single command
    function [`FCI_DW-1:0] first_byte;
        input [2:0] o;
        input [`FCI_DW-1:0] d;
        begin
            case (o)
                `FCI_OP_WRITE: first_byte = `FCI_CMD_WRITE_SETUP; // R15
                `FCI_OP_ERASE: first_byte = `FCI_CMD_ERASE_SETUP; // R15
                `FCI_OP_READ_ARRAY: first_byte = `FCI_CMD_READ_ARRAY; // R12 R16
                `FCI_OP_SUSPEND: first_byte = `FCI_CMD_SUSPEND; // R13
                `FCI_OP_READ_ID: first_byte = `FCI_CMD_READ_ID; // R18
                default: first_byte = d;
            endcase
        end
    endfunction

    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state <= S_IDLE;
            op <= `FCI_OP_READ;
            second <= 1'b0;
            is_read <= 1'b0;
            wr_byte <= {`FCI_DW{1'b0}};
            data_byte <= {`FCI_DW{1'b0}};
            tload <= 1'b0;
            tval <= {`FCI_CW{1'b0}};
            req_ready <= 1'b0;
            rsp_valid <= 1'b0;
            rsp_data <= {`FCI_DW{1'b0}};
            engine_busy <= 1'b0;
            // Flash held in power-down while the controller is in reset
            reset_powerdown_n <= 1'b0; // R3
            chip_enable_n <= 1'b1;
            output_enable_n <= 1'b1;
            write_enable_n <= 1'b1;
            byte_address_bus <= {`FCI_AW{1'b0}};
            byte_data_out <= {`FCI_DW{1'b0}};
            byte_data_oe_n <= 1'b1;
        end else begin
            tload <= 1'b0;
            rsp_valid <= 1'b0;
            // Ready pin is sampled once, so busy lags it by one cycle
            if (!reset_powerdown_n) begin
                engine_busy <= 1'b0; // R9
            end else begin
                engine_busy <= ~engine_ready_flag; // R8
            end
            case (state)
                S_IDLE: begin
                    // Requests are only taken between bus cycles
                    reset_powerdown_n <= 1'b1; // R4
                    req_ready <= 1'b1;
                    if (req_valid && req_ready) begin
                        req_ready <= 1'b0;
                        op <= req_op;
                        if (req_op == `FCI_OP_PWRDN) begin
                            reset_powerdown_n <= 1'b0; // R3
                            state <= S_PDN;
                        end else begin
                            is_read <= (req_op == `FCI_OP_READ);
                            second <= 1'b0;
                            wr_byte <= first_byte(req_op, req_data);
                            // Kept for the second write, so req_data may change
                            data_byte <= req_data;
                            byte_address_bus <= req_addr; // R6 R14
                            tval <= `FCI_T_SETUP;
                            tload <= 1'b1;
                            state <= S_SETUP;
                        end
                    end
                end
                S_SETUP: begin
                    chip_enable_n <= 1'b0; // R2
                    // Host drives the data bus for the whole write cycle
                    if (!is_read) begin
                        byte_data_out <= wr_byte;
                        byte_data_oe_n <= 1'b0; // R7
                    end
                    if (tdone && !tload) begin
                        if (is_read) begin
                            output_enable_n <= 1'b0; // R5 R10
                            tval <= `FCI_T_READ;
                        end else begin
                            write_enable_n <= 1'b0; // R1
                            tval <= `FCI_T_STROBE;
                        end
                        tload <= 1'b1;
                        state <= S_STROBE;
                    end
                end
                S_STROBE: begin
                    if (tdone && !tload) begin
                        if (is_read) begin
                            // Read byte is taken while OE is still low
                            rsp_data <= byte_data_in; // R7 R17
                            rsp_valid <= 1'b1;
                            output_enable_n <= 1'b1; // R5
                        end else begin
                            write_enable_n <= 1'b1; // R19
                        end
                        tval <= `FCI_T_HOLD;
                        tload <= 1'b1;
                        state <= S_HOLD;
                    end
                end
                S_HOLD: begin
                    // CE and data stay put after WE rises so the byte latches cleanly
                    if (tdone && !tload) begin
                        chip_enable_n <= 1'b1; // R2
                        byte_data_oe_n <= 1'b1;
                        state <= S_GAP;
                    end
                end
                S_GAP: begin
                    // Strobe-free cycle after each bus cycle; starts the second write of a sequence
                    if (!second && (op == `FCI_OP_WRITE || op == `FCI_OP_ERASE)) begin
                        second <= 1'b1; // R11
                        if (op == `FCI_OP_ERASE) begin
                            wr_byte <= `FCI_CMD_ERASE_CONFIRM; // R11 R14
                        end else begin
                            wr_byte <= data_byte; // R7
                        end
                        tval <= `FCI_T_SETUP;
                        tload <= 1'b1;
                        state <= S_SETUP;
                    end else begin
                        state <= S_IDLE;
                    end
                end
                S_PDN: begin
                    // The op that wakes the flash is consumed, not executed
                    if (req_valid && req_ready && req_op != `FCI_OP_PWRDN) begin
                        req_ready <= 1'b0;
                        reset_powerdown_n <= 1'b1; // R4
                        tval <= `FCI_T_WAKE;
                        tload <= 1'b1;
                        state <= S_WAKE;
                    end else begin
                        req_ready <= 1'b1;
                    end
                end
                S_WAKE: begin
                    // Flash needs recovery time after deep power-down
                    if (tdone && !tload) begin
                        state <= S_IDLE;
                    end
                end
                default: state <= S_IDLE;
            endcase
        end
    end
endmodule // fci_host_ctrl

// ### dv/fci_flash_model.sv
// Behavioural byte-wide flash seen at its pins, sampled on mclk
// Assumes the host moves its pins just after mclk edges
module fci_flash_model #(parameter MFR = 8'h3C, DEV = 8'hC3) ( // Arbitrary ID codes
    input wire mclk, rp_n, ce_n, oe_n, we_n,
    input wire [20:0] a,
    input wire [7:0] d,
    output reg [7:0] q,
    output wire ready
);
    timeunit 1ns / 1ns;
    reg [20:0] wa = 21'h000000;
    reg [7:0] wd = 8'h00, pend;
    reg [5:0] busy;
    reg [1:0] mode;
    reg we_q;
    assign ready = busy == 6'h00;
    always @(posedge mclk or negedge rp_n) begin
        if (!rp_n) begin
            {mode, pend, busy, we_q, q} <= 25'h0000100;
        end else begin
            we_q <= we_n;
            busy <= busy - {5'h00, !ready};
            q <= (ce_n || oe_n) ? ~q : mode == 2'h1 ? {ready, 7'h00} :
                mode == 2'h2 ? (a[0] ? DEV : MFR) : a == wa ? wd : a[7:0];
            if (we_n && !we_q && !ce_n) begin
                pend <= d;
                if (pend == 8'h20 && d == 8'hD0)
                    {wd, busy, mode} <= {a[20:16] == wa[20:16] ? 8'hFF : wd, 6'h3C, 2'h1};
                else if (pend == 8'h40 || pend == 8'h10)
                    {wa, wd, busy, mode, pend} <= {a, d, 6'h14, 2'h1, 8'h00};
                else if (d == 8'hB0)
                    busy <= 6'h00;
                else
                    mode <= d == 8'hFF ? 2'h0 : d == 8'h90 ? 2'h2 : mode;
            end
        end
    end
endmodule // fci_flash_model

// ### dv/fci_host_ctrl_assertions.sv
// Pin-level assertions on the host flash controller
// Assumes only the controller's ports; bound after endmodule
module fci_host_ctrl_chk (
    input logic mclk, rst_n, rsp_valid, engine_busy, engine_ready_flag, reset_powerdown_n,
    input logic chip_enable_n, output_enable_n, write_enable_n, byte_data_oe_n,
    input logic [20:0] byte_address_bus,
    input logic [7:0] byte_data_out
);
    timeunit 1ns / 1ns;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    a_strobe_excl: assert property (output_enable_n || write_enable_n)
        else $error("strobes overlap");
    a_read_sel: assert property (!output_enable_n |-> !chip_enable_n && byte_data_oe_n)
        else $error("bad read select");
    a_write_sel: assert property (!write_enable_n |-> !chip_enable_n && !byte_data_oe_n)
        else $error("bad write select");
    a_pd_quiet: assert property (!reset_powerdown_n |-> chip_enable_n && write_enable_n)
        else $error("strobe in power-down");
    a_we_hold: assert property ($fell(write_enable_n) |-> (!write_enable_n &&
        $stable(byte_data_out) && $stable(byte_address_bus))[*4] ##1 write_enable_n)
        else $error("write pulse wrong");
    a_read_len: assert property ($fell(output_enable_n) |->
        !output_enable_n[*4] ##1 (output_enable_n && rsp_valid))
        else $error("read pulse wrong");
    a_busy_track: assert property (reset_powerdown_n && $past(reset_powerdown_n) |->
        engine_busy == !$past(engine_ready_flag))
        else $error("busy not tracking");
    a_pd_ready: assert property (!reset_powerdown_n && !$past(reset_powerdown_n) |->
        !engine_busy)
        else $error("busy in power-down");
endmodule // fci_host_ctrl_chk
bind fci_host_ctrl fci_host_ctrl_chk chk (.mclk, .rst_n, .rsp_valid, .engine_busy,
    .engine_ready_flag, .reset_powerdown_n, .chip_enable_n, .output_enable_n,
    .write_enable_n, .byte_data_oe_n, .byte_address_bus, .byte_data_out);

// ### dv/flash_command_interface_bench.sv
// Bench: host flash controller driving a behavioural flash
// Assumes fci_flash_model and the bound pin checker
module flash_command_interface_bench;
    timeunit 1ns / 1ns;
    localparam logic [7:0] MFR = 8'h3C, DEV = 8'hC3; // Arbitrary values
    logic mclk = 0, rst_n = 0, req_valid = 0;
    logic [2:0] req_op = 3'h0;
    logic [20:0] req_addr = 21'h000000;
    logic [7:0] req_data = 8'h00, got;
    wire req_ready, rsp_valid, engine_busy, reset_powerdown_n, chip_enable_n;
    wire output_enable_n, write_enable_n, byte_data_oe_n, engine_ready_flag;
    wire [7:0] rsp_data, byte_data_out, byte_data_in;
    wire [20:0] byte_address_bus;
    int num_errors = 0, n_tests = 0;
    fci_host_ctrl dut (.mclk(mclk), .rst_n(rst_n), .req_valid(req_valid), .req_op(req_op),
        .req_addr(req_addr), .req_data(req_data), .req_ready(req_ready), .rsp_valid(rsp_valid),
        .rsp_data(rsp_data), .engine_busy(engine_busy), .reset_powerdown_n(reset_powerdown_n),
        .chip_enable_n(chip_enable_n), .output_enable_n(output_enable_n),
        .write_enable_n(write_enable_n), .byte_address_bus(byte_address_bus),
        .byte_data_out(byte_data_out), .byte_data_oe_n(byte_data_oe_n),
        .byte_data_in(byte_data_in), .engine_ready_flag(engine_ready_flag));
    fci_flash_model #(.MFR(MFR), .DEV(DEV)) flash (.mclk(mclk), .rp_n(reset_powerdown_n),
        .ce_n(chip_enable_n),
        .oe_n(output_enable_n), .we_n(write_enable_n), .a(byte_address_bus), .q(byte_data_in),
        .d(byte_data_oe_n ? byte_data_in : byte_data_out), .ready(engine_ready_flag));
    initial forever #50 mclk = ~mclk;
    task check(input logic [7:0] seen, exp);
        n_tests++;
        if (seen !== exp) num_errors++;
        if (seen !== exp) $display("mismatch t=%0t got=%h exp=%h", $time, seen, exp);
    endtask
    task end_sim;
        $display("checks %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic run(input logic [2:0] o, input logic [20:0] a = 0, input logic [7:0] d = 0);
        int i = 0;
        {req_op, req_addr, req_data, req_valid} <= {o, a, d, 1'b1};
        got = 8'hXX;
        do @(posedge mclk); while (req_ready !== 1'b1 && ++i < 40);
        req_valid <= 1'b0;
        do begin
            @(posedge mclk);
            if (rsp_valid === 1'b1) got = rsp_data;
        end while (req_ready !== 1'b1 && ++i < 80);
        if (i >= 80) num_errors++;
        if (i >= 80) end_sim;
    endtask
    task t_program;
        run(3'h1, 21'h010123, 8'hA5);
        check(engine_busy, 1);
        for (int i = 0; i < 99 && engine_busy !== 1'b0; i++) @(posedge mclk);
        check(engine_busy, 0);
        run(3'h0);
        check(got, 8'h80);
        run(3'h3);
        run(3'h0, 21'h010123);
        check(got, 8'hA5);
        $display("program test done");
    endtask
    task t_erase;
        run(3'h2, 21'h01BEEF);
        check(engine_busy, 1);
        run(3'h4);
        check(engine_busy, 0);
        run(3'h3);
        run(3'h0, 21'h010123);
        check(got, 8'hFF);
        $display("erase test done");
    endtask
    task t_id_pd;
        run(3'h5);
        run(3'h0, 21'h000000);
        check(got, MFR);
        run(3'h0, 21'h000001);
        check(got, DEV);
        run(3'h6);
        @(posedge mclk);
        check(reset_powerdown_n, 0);
        run(3'h0);
        @(posedge mclk);
        check(reset_powerdown_n, 1);
        run(3'h0, 21'h000042);
        check(got, 8'h42);
        $display("id and power-down test done");
    endtask
    task t_reset;
        rst_n <= 1'b0;
        repeat (3) @(posedge mclk);
        check(reset_powerdown_n, 0);
        rst_n <= 1'b1;
        repeat (2) @(posedge mclk);
        check(reset_powerdown_n, 1);
        run(3'h0, 21'h000055);
        check(got, 8'h55);
        $display("mid-run reset test done");
    endtask
    initial begin
        repeat (3) @(posedge mclk);
        check(reset_powerdown_n, 0);
        rst_n <= 1'b1;
        @(posedge mclk);
        t_program;
        t_erase;
        t_id_pd;
        t_reset;
        end_sim;
    end
endmodule // flash_command_interface_bench

// ### include/fci_defs.vh
// Constants for the host-side flash command controller
// Assumes a byte-wide block-erasable flash with active-low strobes
`ifndef FCI_DEFS_VH
`define FCI_DEFS_VH
`define FCI_AW 21
`define FCI_DW 8
`define FCI_BLK_W 5
`define FCI_BLK_LSB 16
`define FCI_CMD_ERASE_SETUP 8'h20
`define FCI_CMD_ERASE_CONFIRM 8'hD0
`define FCI_CMD_WRITE_SETUP 8'h40
`define FCI_CMD_READ_ARRAY 8'hFF
`define FCI_CMD_SUSPEND 8'hB0
`define FCI_CMD_READ_ID 8'h90
`define FCI_ID_MFR_ADDR 21'h000000
`define FCI_ID_DEV_ADDR 21'h000001
`define FCI_OP_READ 3'h0
`define FCI_OP_WRITE 3'h1
`define FCI_OP_ERASE 3'h2
`define FCI_OP_READ_ARRAY 3'h3
`define FCI_OP_SUSPEND 3'h4
`define FCI_OP_READ_ID 3'h5
`define FCI_OP_PWRDN 3'h6
// Timer loads in 100 ns cycles; each phase lasts its load plus two: setup, strobe low, hold, read, wake
`define FCI_T_SETUP 3'h1
`define FCI_T_STROBE 3'h2
`define FCI_T_HOLD 3'h1
`define FCI_T_READ 3'h2
`define FCI_T_WAKE 3'h3
`define FCI_CW 3
`endif
